// ### sog_defs.svh
// timing, width and reset constants of the serial output gating block
// assumes a 250 MHz mclk; included by name wherever needed
`ifndef SOG_DEFS_SVH
`define SOG_DEFS_SVH

`define SOG_MCLK_NS       4
`define SOG_RES_W         12
`define SOG_FIFO_DEPTH    16
`define SOG_CONVERT_START_N_TIME_NS  20000
`define SOG_CONVERT_START_N_CYC      ((`SOG_CONVERT_START_N_TIME_NS + `SOG_MCLK_NS - 1) / `SOG_MCLK_NS)
`define SOG_IHALF_NS      32
`define SOG_IHALF_CYC     ((`SOG_IHALF_NS + `SOG_MCLK_NS - 1) / `SOG_MCLK_NS)
`define SOG_SHREG_RST     12'h000

`endif

// ### sog_pkg.sv
// types shared by the serial output gating block
// assumes sog_defs.svh is on the include path
`include "sog_defs.svh"
package sog_pkg;

  typedef enum logic [0:0] {
    SOG_IDLE = 1'b0,
    SOG_CONVERT_START_N = 1'b1
  } sog_state_e;

  typedef struct packed {
    logic [`SOG_RES_W-1:0] code;
  } sog_word_s;

  typedef struct packed {
    logic data;
    logic data_oe;
    logic clk;
    logic clk_oe;
  } sog_pins_s;

endpackage

// ### sog_fifo.sv
// synchronous valid/ready fifo for conversion results
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module sog_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    wp_nxt;
  logic [AW-1:0]    rp_r;
  logic [AW-1:0]    rp_nxt;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r;
    if (push & ~pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop & ~push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; count guards reads
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule

// ### sog_core.sv
// serial result readout and output gating of a 12-bit sar converter
// assumes pins arrive asynchronous to mclk; results come from the sar through a fifo
//
// Operation
// - chip select high disables data and clock outputs and blocks external clock.
// - chip select may rise anytime; outputs drop, conversion sequencing continues untouched.
// - falling convert edge starts a conversion whatever chip select shows.
// - internal mode shifts out even with chip select high; outputs stay disabled.
// - internal mode sends prior result msb first during conversion; idle lines low.
// - external first rising edge starts transfer; each bit valid at falling edge.
// - new result loads only if the fifo holds one: then always in internal mode; in external mode only if external clock low or select high before busy.
// - beyond twelve external clocks, data goes low from the thirteenth rising edge.
`timescale 1ns/10ps
`include "sog_defs.svh"
module sog_core
  import sog_pkg::*;
#(
  parameter int CONVERT_START_N_CYC  = `SOG_CONVERT_START_N_CYC,
  parameter int IHALF_CYC = `SOG_IHALF_CYC,
  parameter int RES_W     = `SOG_RES_W,
  parameter int DEPTH     = `SOG_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // host pins
  input  wire logic             convert_start_n,
  input  wire logic             chip_select_n,
  input  wire logic             shift_clock_source_select,
  input  wire logic             serial_shift_clock_in,
  output logic                  serial_shift_clock_out,
  output logic                  serial_shift_clock_oe,
  output logic                  serial_data_out,
  output logic                  serial_data_oe,
  output logic                  busy_n,
  // results from the sar
  input  wire logic             result_valid,
  output logic                  result_ready,
  input  wire logic [RES_W-1:0] result_code
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic       ck_d_r;
  logic       cv_d_r;
  logic       cv_s;
  logic       cs_s;
  logic       ext_s;
  logic       ck_s;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s1_r   <= 4'h3;
      s2_r   <= 4'h3;
      ck_d_r <= 1'b0;
      cv_d_r <= 1'b1;
    end else begin
      s1_r   <= {serial_shift_clock_in, shift_clock_source_select, chip_select_n, convert_start_n};
      s2_r   <= s1_r;
      ck_d_r <= s2_r[3];
      cv_d_r <= s2_r[0];
    end
  end

  assign cv_s  = s2_r[0];
  assign cs_s  = s2_r[1];
  assign ext_s = s2_r[2];
  assign ck_s  = s2_r[3];

  ////////////////////////////////////////////////////////////////////////////
  // result fifo
  sog_word_s fifo_word;
  logic      fifo_valid;
  logic      convert_start_n_end;

  sog_fifo #(
    .WIDTH (RES_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (result_valid),
    .in_ready  (result_ready),
    .in_data   (result_code),
    .out_valid (fifo_valid),
    .out_ready (convert_start_n_end),
    .out_data  (fifo_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencing
  sog_state_e state_r;
  sog_state_e state_nxt;
  logic [15:0] ccnt_r;
  logic [15:0] ccnt_nxt;
  logic        convert_start_n_start;

  always_comb begin
    state_nxt  = state_r;
    ccnt_nxt   = ccnt_r;
    convert_start_n_start = 1'b0;
    convert_start_n_end   = 1'b0;
    unique case (state_r)
      SOG_IDLE: begin
        if (cv_d_r & ~cv_s) begin
          convert_start_n_start = 1'b1;
          state_nxt  = SOG_CONVERT_START_N;
          ccnt_nxt   = '0;
        end
      end
      SOG_CONVERT_START_N: begin
        if (ccnt_r == 16'(CONVERT_START_N_CYC - 1)) begin
          convert_start_n_end  = 1'b1;
          state_nxt = SOG_IDLE;
        end else begin
          ccnt_nxt = 16'(ccnt_r + 1'b1);
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r <= SOG_IDLE;
      ccnt_r  <= '0;
    end else begin
      state_r <= state_nxt;
      ccnt_r  <= ccnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift register and serial engine
  logic [RES_W-1:0] shreg_r;
  logic [RES_W-1:0] shreg_nxt;
  logic [3:0]       xcnt_r;
  logic [3:0]       xcnt_nxt;
  logic             itx_r;
  logic             itx_nxt;
  logic [3:0]       ibit_r;
  logic [3:0]       ibit_nxt;
  logic [7:0]       iph_r;
  logic [7:0]       iph_nxt;
  logic             iclk_r;
  logic             iclk_nxt;
  logic             sd_r;
  logic             sd_nxt;
  logic             ck_rise;
  logic [3:0]       xidx;
  logic [3:0]       iidx;

  assign ck_rise = ck_s & ~ck_d_r;
  assign xidx    = 4'(RES_W - 1) - xcnt_r;
  assign iidx    = 4'(RES_W - 2) - ibit_r;

  always_comb begin
    shreg_nxt = shreg_r;
    xcnt_nxt  = xcnt_r;
    itx_nxt   = itx_r;
    ibit_nxt  = ibit_r;
    iph_nxt   = iph_r;
    iclk_nxt  = iclk_r;
    sd_nxt    = sd_r;
    if (convert_start_n_start & ~ext_s) begin
      itx_nxt  = 1'b1;
      ibit_nxt = '0;
      iph_nxt  = '0;
      iclk_nxt = 1'b0;
      sd_nxt   = shreg_r[RES_W-1];
    end else if (itx_r) begin
      if (iph_r == 8'(IHALF_CYC - 1)) begin
        iph_nxt  = '0;
        iclk_nxt = ~iclk_r;
        // data changes in the same cycle the clock falls, so it holds while clock high and is valid at the rising edge only
        if (iclk_r) begin
          ibit_nxt = 4'(ibit_r + 1'b1);
          if (ibit_r == 4'(RES_W - 1)) begin
            itx_nxt = 1'b0;
            sd_nxt  = 1'b0;
          end else begin
            sd_nxt = shreg_r[iidx];
          end
        end
      end else begin
        iph_nxt = 8'(iph_r + 1'b1);
      end
    end else if (~ext_s) begin
      // idle data low, clears external leftovers
      sd_nxt = 1'b0;
    end
    if (ext_s & ~cs_s & ck_rise) begin
      if (xcnt_r < 4'(RES_W)) begin
        sd_nxt   = shreg_r[xidx];
        xcnt_nxt = 4'(xcnt_r + 1'b1);
      end else begin
        sd_nxt = 1'b0;
      end
    end
    // conversion end stops any straggling internal frame
    if (convert_start_n_end) begin
      itx_nxt  = 1'b0;
      iclk_nxt = 1'b0;
      // relies on host clock low here
      if (fifo_valid & (~ext_s | ~ck_s | cs_s)) begin
        shreg_nxt = fifo_word.code;
        xcnt_nxt  = '0;
        sd_nxt    = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      shreg_r <= `SOG_SHREG_RST;
      xcnt_r  <= 4'h0;
      itx_r   <= 1'b0;
      ibit_r  <= 4'h0;
      iph_r   <= 8'h00;
      iclk_r  <= 1'b0;
      sd_r    <= 1'b0;
    end else begin
      shreg_r <= shreg_nxt;
      xcnt_r  <= xcnt_nxt;
      itx_r   <= itx_nxt;
      ibit_r  <= ibit_nxt;
      iph_r   <= iph_nxt;
      iclk_r  <= iclk_nxt;
      sd_r    <= sd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output gating
  sog_pins_s pins;

  always_comb begin
    pins.data    = sd_r;
    pins.clk     = iclk_r;
    pins.data_oe = ~cs_s;
    pins.clk_oe  = ~cs_s & ~ext_s;
  end

  assign serial_data_out        = pins.data;
  assign serial_data_oe         = pins.data_oe;
  assign serial_shift_clock_out = pins.clk;
  assign serial_shift_clock_oe  = pins.clk_oe;
  assign busy_n                 = (state_r == SOG_IDLE);
endmodule

// ### sog_checker.sv
// pin assertions for sog_core
// assumes pins change away from mclk edges
`timescale 1ns/10ps
module sog_checker #(
  parameter int CONVERT_START_N_CYC  = 5000,
  parameter int IHALF_CYC = 8,
  parameter int RES_W     = 12,
  parameter int DEPTH     = 16
) (
  // clock and reset
  input wire logic             mclk,
  input wire logic             resetn,
  // host pins
  input wire logic             convert_start_n,
  input wire logic             chip_select_n,
  input wire logic             shift_clock_source_select,
  input wire logic             serial_shift_clock_in,
  input wire logic             serial_shift_clock_out,
  input wire logic             serial_shift_clock_oe,
  input wire logic             serial_data_out,
  input wire logic             serial_data_oe,
  input wire logic             busy_n,
  // results from the sar
  input wire logic             result_valid,
  input wire logic             result_ready,
  input wire logic [RES_W-1:0] result_code
);
  logic [1:0] up_r, up_nxt;
  int         bc_r, bc_nxt;
  // sync delay must pass before gating is judged
  always_comb begin
    up_nxt = !resetn ? 2'h0 : (up_r == 2'h3) ? up_r : up_r + 2'h1;
    bc_nxt = (!resetn || busy_n) ? 0 : bc_r + 1;
  end
  always_ff @(posedge mclk) begin
    up_r <= up_nxt;
    bc_r <= bc_nxt;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  data_gate_a: assert property (up_r == 2'h3 |-> serial_data_oe == !$past(chip_select_n, 2))
    else $error("data enable wrong");
  clk_gate_a: assert property (up_r == 2'h3 |->
    serial_shift_clock_oe == (!$past(chip_select_n, 2) && !$past(shift_clock_source_select, 2)))
    else $error("clock enable wrong");
  idle_low_a: assert property (busy_n && !shift_clock_source_select && !$past(shift_clock_source_select, 3)
    |-> !serial_shift_clock_out && !serial_data_out) else $error("idle lines not low");
  convert_start_n_start_a: assert property (busy_n && $fell(convert_start_n) |-> ##[1:5] !busy_n)
    else $error("conversion not started");
  convert_start_n_len_a: assert property ($rose(busy_n) |-> bc_r inside {[CONVERT_START_N_CYC-1:CONVERT_START_N_CYC+1]})
    else $error("conversion length wrong");
  frame_start_a: assert property ($fell(busy_n) && !shift_clock_source_select
    |-> ##[4:10] $rose(serial_shift_clock_out)) else $error("internal frame missing");
  clk_high_a: assert property ($rose(serial_shift_clock_out)
    |-> serial_shift_clock_out[*8] ##1 !serial_shift_clock_out) else $error("clock high time wrong");
  data_hold_a: assert property (serial_shift_clock_out |-> $stable(serial_data_out))
    else $error("data moved while clock high");
  cover property ($fell(busy_n) && chip_select_n);
  cover property ($rose(serial_shift_clock_in) && shift_clock_source_select && !chip_select_n);
  cover property ($rose(serial_shift_clock_out) && serial_shift_clock_oe);
endmodule
bind sog_core sog_checker #(.CONVERT_START_N_CYC(CONVERT_START_N_CYC), .IHALF_CYC(IHALF_CYC), .RES_W(RES_W), .DEPTH(DEPTH)) chk (
  .mclk, .resetn, .convert_start_n, .chip_select_n, .shift_clock_source_select, .serial_shift_clock_in,
  .serial_shift_clock_out, .serial_shift_clock_oe, .serial_data_out, .serial_data_oe, .busy_n,
  .result_valid, .result_ready, .result_code);

// ### sog_host.sv
// host model: convert pulses, external shift clock, word collection
// assumes the bench owns chip select
`timescale 1ns/10ps
module sog_host (
  // device pins
  input wire logic  busy_n,
  input wire logic  sdo,
  input wire logic  sdo_oe,
  input wire logic  sck,
  input wire logic  sck_oe,
  input wire logic  ext,
  // host pins
  output logic      convert_start_n_n = 1'b1,
  output logic      xck = 1'b0,
  // collected word
  output logic [11:0] acc = 12'h000,
  output logic      xb = 1'b0
);
  logic dl = 1'b0;
  int   nb = 0;
  event got;
  // released data pin shows the inverse level
  wire  dp = sdo_oe ? sdo : ~dl;
  always @(sdo_oe or sdo) if (sdo_oe) dl = sdo;
  task automatic take(input logic b);
    if (nb < 12) begin
      acc = {acc[10:0], b};
      nb++;
      if (nb == 12) ->got;
    end else xb = b;
  endtask
  always @(negedge busy_n) if (!ext) nb = 0;
  always @(posedge sck) if (sck_oe && !ext) take(dp);
  // clock rests low, sampled before fall
  task automatic rd(input int n, input bit fresh);
    if (fresh) nb = 0;
    repeat (n) begin
      xck = 1'b1;
      #24 take(dp);
      xck = 1'b0;
      #24;
    end
  endtask
  task automatic level(input logic v);
    xck = v;
  endtask
  task automatic cv();
    convert_start_n_n = 1'b0;
    #100 convert_start_n_n = 1'b1;
  endtask
endmodule

// ### tb_top.sv
// bench for sog_core with host model and fed result fifo
// assumes the checker binds itself
`timescale 1ns/10ps
module tb_top;
  logic        mclk = 0, resetn = 0, ext = 0, rv = 0, cs_n = 0;
  logic [11:0] rc = 0, sr = 0, acc;
  logic        rr, sck, sck_oe, sdo, sdo_oe, busy_n, convert_start_n_n, xck, xb;
  logic [11:0] eq[$], fq[$];
  int          mismatches = 0, checked = 0, seed = 23, n;
  always #2 mclk = ~mclk;
  sog_core #(.CONVERT_START_N_CYC(300)) uut (.mclk(mclk), .resetn(resetn), .convert_start_n(convert_start_n_n),
    .chip_select_n(cs_n), .shift_clock_source_select(ext), .serial_shift_clock_in(xck),
    .serial_shift_clock_out(sck), .serial_shift_clock_oe(sck_oe), .serial_data_out(sdo),
    .serial_data_oe(sdo_oe), .busy_n(busy_n), .result_valid(rv), .result_ready(rr), .result_code(rc));
  sog_host host (.busy_n(busy_n), .sdo(sdo), .sdo_oe(sdo_oe), .sck(sck), .sck_oe(sck_oe),
    .ext(ext), .convert_start_n_n(convert_start_n_n), .xck(xck), .acc(acc), .xb(xb));
  //////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wb(input logic v);
    for (n = 0; n < 2000 && busy_n !== v; n++) @(posedge mclk) #1;
    if (busy_n !== v) chk(12'h001, 12'h000);
  endtask
  task automatic run(input int i);
    logic ld;
    ld = 1'b1;
    ext = (i >= 6 && i <= 10);
    cs_n = (i == 3);
    repeat (4) @(posedge mclk);
    #1;
    if (!ext && i != 3 && i != 4) eq.push_back(sr);
    fork
      host.cv();
    join_none
    wb(1'b0);
    if (i == 4) begin
      repeat (100) @(posedge mclk);
      #1;
      cs_n = 1'b1;
    end
    if (i == 9) host.rd(5, 1'b0);
    if (i == 9) chk({11'h000, xb}, 12'h000);
    if (i == 10) begin
      host.level(1'b1);
      ld = 1'b0;
    end
    wb(1'b1);
    host.level(1'b0);
    if (fq.size() > 0) begin
      if (ld) sr = fq.pop_front();
      else void'(fq.pop_front());
    end
    if (i >= 6 && i <= 8) begin
      eq.push_back(sr);
      // clocks with select high must not shift
      if (i == 7) begin
        cs_n = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        host.rd(3, 1'b1);
        cs_n = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
      end
      host.rd((i == 8) ? 8 : 13, 1'b1);
    end
    if (i == 6 || i == 7) chk({11'h000, xb}, 12'h000);
    $display("conversion %0d done", i);
  endtask
  always @(host.got) chk(acc, eq.size() ? eq.pop_front() : ~acc);
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge mclk);
    #1;
    resetn = 1;
    // fill until refused, converter stalls meanwhile
    for (int k = 0; k < 17; k++) begin
      rc = 12'($random(seed));
      rv = 1;
      if (rr === 1'b1) fq.push_back(rc);
      @(posedge mclk) #1;
    end
    rv = 0;
    chk(12'(fq.size()), 12'h010);
    for (int i = 0; i < 18; i++) run(i);
    repeat (10) @(posedge mclk);
    chk(12'(eq.size()), 12'h000);
    final_report();
  end
endmodule
